/* File: hdl/adcs_defs.vh */
// constants for the conversion sequencer: register offsets, field positions,
// reset values and timing counts. included by adcs_seq.v only.
`ifndef ADCS_DEFS_VH
`define ADCS_DEFS_VH

// ----------------------------------------------------------------
// register offsets (3-bit byte address)
// ----------------------------------------------------------------
`define ADCS_ADDR_CHAN_CTRL   3'h0
`define ADCS_ADDR_TIMING_FMT  3'h1
`define ADCS_ADDR_RESULT_HIGH 3'h2
`define ADCS_ADDR_RESULT_LOW  3'h3
`define ADCS_ADDR_PERIPH_FLAG 3'h4
`define ADCS_ADDR_PERIPH_EN   3'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADCS_BIT_ON       0
`define ADCS_BIT_GO       1
`define ADCS_CHS_LSB      2
`define ADCS_CHS_MSB      5
`define ADCS_CLK_LSB      0
`define ADCS_CLK_MSB      2
`define ADCS_ACQ_LSB      3
`define ADCS_ACQ_MSB      5
`define ADCS_BIT_JUSTIFY  7
`define ADCS_BIT_DONE     6
`define ADCS_BIT_IRQ_EN   6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ADCS_RST_CHAN_CTRL  8'h00
`define ADCS_RST_TIMING_FMT 8'h00
`define ADCS_RST_RESULT     10'h000

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define ADCS_CONV_TADS      5'd11
`define ADCS_WAIT_TADS      5'd2
`define ADCS_INSTR_CLKS     4'd4
`define ADCS_RES_BITS       10

`endif

/* File: hdl/adcs_seq.v */
// conversion sequencer for a 10-bit successive-approximation converter.
// assumes an analog core that samples while sample_connect is high and
// answers each trial code on dac_code with cmp_in; frc_clk is asynchronous.
//
// Function
// - done flag is set at every conversion end, regardless of interrupt enable
// - done flag stays set until software clears it
// - done flag with enable set during sleep raises wake request
// - 3-bit clock select picks system divider or internal rc clock
// - 10-bit result delivered left or right justified in two registers
// - justify bit one is right justified, zero is left justified
// - enable bit 0 set turns converter on; clear keeps it idle
// - start runs acquisition delay first unless acquisition field is zero
// - acquisition code 010 gives four conversion clock periods
// - acquisition codes decode to 0,2,4,6,8,12,16,20 periods
// - zero acquisition delays conversion by one instruction cycle
// - one full conversion takes eleven conversion clock periods
// - completion clears start bit, sets flag, writes result
// - software clearing start aborts; unconverted bits copy last converted bit
// - reset returns all registers to defaults and stops conversion
// - two periods wait after end before channel reconnects
// - rc clock adds one instruction cycle before converting
// - sleep with rc clock: off after end if no interrupt, else wake
// - sleep with other clock aborts and powers down, enable bit kept
// - special event trigger sets start bit and resets timer
// - 4-bit channel field at bits 5-2 selects the input
`timescale 1ns/1ps
`include "adcs_defs.vh"

module adcs_seq #(
  parameter INSTR_CLKS = 4
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // register port
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // power state and trigger
  input  wire       sleep_mode,
  input  wire       special_event_trig,
  output reg        timer_reset,
  output reg        wake_req,
  // analog core
  input  wire       frc_clk,
  input  wire       cmp_in,
  output reg  [3:0] channel_select,
  output reg        sample_connect,
  output reg        converter_power,
  output reg        conv_active,
  output reg  [9:0] dac_code
);
  // ----------------------------------------------------------------
  // states and helpers
  // ----------------------------------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_DLY  = 3'd1;
  localparam S_ACQ  = 3'd2;
  localparam S_CONV = 3'd3;
  localparam S_WAIT = 3'd4;
  // system clocks per conversion clock period
  function [6:0] clk_div;
    input [2:0] sel;
    begin
      case (sel)
        3'b000:  clk_div = 7'd2;
        3'b100:  clk_div = 7'd4;
        3'b001:  clk_div = 7'd8;
        3'b101:  clk_div = 7'd16;
        3'b010:  clk_div = 7'd32;
        3'b110:  clk_div = 7'd64;
        default: clk_div = 7'd1;
      endcase
    end
  endfunction
  function [4:0] acq_tads;
    input [2:0] sel;
    begin
      case (sel)
        3'b000:  acq_tads = 5'd0;
        3'b001:  acq_tads = 5'd2;
        3'b010:  acq_tads = 5'd4;
        3'b011:  acq_tads = 5'd6;
        3'b100:  acq_tads = 5'd8;
        3'b101:  acq_tads = 5'd12;
        3'b110:  acq_tads = 5'd16;
        default: acq_tads = 5'd20;
      endcase
    end
  endfunction
  // bits below the converted ones take the last converted bit
  function [9:0] fill_partial;
    input [9:0] code;
    input [3:0] nbits;
    input       last;
    integer     i;
    begin
      fill_partial = code;
      for (i = 0; i < `ADCS_RES_BITS; i = i + 1) begin
        if (i < (`ADCS_RES_BITS - nbits))
          fill_partial[i] = last;
      end
    end
  endfunction
  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg  [3:0] chs;
  reg        go;
  reg        conv_on;
  reg        justify_select;
  reg  [2:0] acq_sel;
  reg  [2:0] clk_sel;
  reg  [9:0] result;
  reg        conv_done_flag;
  reg        conv_irq_enable;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [6:0] presc;
  reg  [4:0] tad_cnt;
  reg  [3:0] dly_cnt;
  reg  [3:0] nbits;
  reg        last_bit;
  reg        sleep_off;
  reg        cmp_s1;
  reg        cmp_s2;
  reg        frc_s1;
  reg        frc_s2;
  reg        frc_s3;
  wire       frc_sel   = (clk_sel[1:0] == 2'b11);
  wire       frc_edge  = frc_s2 & ~frc_s3;
  wire [6:0] div       = clk_div(clk_sel);
  wire       tad_tick  = frc_sel ? frc_edge : (presc == div - 7'd1);
  wire [4:0] acq_n     = acq_tads(acq_sel);
  wire       wr_ctrl   = reg_wr & (reg_addr == `ADCS_ADDR_CHAN_CTRL);
  wire       wr_flag   = reg_wr & (reg_addr == `ADCS_ADDR_PERIPH_FLAG);
  wire       sw_go_clr = wr_ctrl & ~reg_wdata[`ADCS_BIT_GO];
  wire       sw_go_set = wr_ctrl & reg_wdata[`ADCS_BIT_GO];
  // non-rc clock in sleep kills the cycle
  wire       sleep_kill = sleep_mode & ~frc_sel & (state != S_IDLE);
  wire [3:0] bit_idx   = 4'd10 - tad_cnt[3:0];
  reg        conv_done;
  reg        conv_abort;
  reg  [9:0] sar_next;
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      frc_s1 <= 1'b0;
      frc_s2 <= 1'b0;
      frc_s3 <= 1'b0;
    end else begin
      cmp_s1 <= cmp_in;
      cmp_s2 <= cmp_s1;
      frc_s1 <= frc_clk;
      frc_s2 <= frc_s1;
      frc_s3 <= frc_s2;
    end
  end
  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    conv_done  = 1'b0;
    conv_abort = 1'b0;
    sar_next   = dac_code;
    if (state == S_CONV && tad_tick && tad_cnt != 5'd0) begin
      sar_next[bit_idx] = cmp_s2;
      if (bit_idx != 4'd0)
        sar_next[bit_idx - 4'd1] = 1'b1;
    end
    case (state)
      S_IDLE: begin
        if (go)
          next_state = S_DLY;
      end
      S_DLY: begin
        if (sw_go_clr)
          next_state = S_WAIT;
        // skip acquisition when field is zero
        else if (dly_cnt == 4'd0)
          next_state = (acq_n == 5'd0) ? S_CONV : S_ACQ;
      end
      S_ACQ: begin
        if (sw_go_clr)
          next_state = S_WAIT;
        else if (tad_tick && tad_cnt == acq_n - 5'd1)
          next_state = S_CONV;
      end
      S_CONV: begin
        if (sw_go_clr) begin
          next_state = S_WAIT;
          conv_abort = 1'b1;
        end else if (tad_tick && tad_cnt == `ADCS_CONV_TADS - 5'd1) begin
          next_state = S_WAIT;
          conv_done  = 1'b1;
        end
      end
      S_WAIT: begin
        if (tad_tick && tad_cnt == `ADCS_WAIT_TADS - 5'd1)
          next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
    if (!conv_on || sleep_kill) begin
      next_state = S_IDLE;
      conv_done  = 1'b0;
      conv_abort = 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // sequencer and register state
  // ----------------------------------------------------------------
  // reset clears every register and stops the cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state           <= S_IDLE;
      chs             <= 4'h0;
      go              <= 1'b0;
      conv_on         <= 1'b0;
      justify_select  <= 1'b0;
      acq_sel         <= 3'h0;
      clk_sel         <= 3'h0;
      result          <= `ADCS_RST_RESULT;
      conv_done_flag  <= 1'b0;
      conv_irq_enable <= 1'b0;
      presc           <= 7'h00;
      tad_cnt         <= 5'h00;
      dly_cnt         <= 4'h0;
      nbits           <= 4'h0;
      last_bit        <= 1'b0;
      sleep_off       <= 1'b0;
      dac_code        <= 10'h000;
    end else begin
      state <= next_state;
      // restart the divider on every state change so periods align
      if (next_state != state || tad_tick)
        presc <= 7'h00;
      else
        presc <= presc + 7'd1;
      if (next_state != state)
        tad_cnt <= 5'h00;
      else if (tad_tick)
        tad_cnt <= tad_cnt + 5'd1;
      // zero acquisition costs one instruction cycle
      if (state == S_IDLE)
        dly_cnt <= ((acq_sel == 3'h0) ? INSTR_CLKS[3:0] : 4'h0)
                 + (frc_sel ? INSTR_CLKS[3:0] : 4'h0);
      else if (dly_cnt != 4'h0)
        dly_cnt <= dly_cnt - 4'd1;
      // successive approximation trial register
      if (next_state == S_CONV && state != S_CONV) begin
        dac_code <= 10'h200;
        nbits    <= 4'h0;
        last_bit <= 1'b0;
      end else if (state == S_CONV && tad_tick && tad_cnt != 5'd0) begin
        dac_code <= sar_next;
        nbits    <= nbits + 4'd1;
        last_bit <= cmp_s2;
      end
      if (conv_done)
        result <= sar_next;
      else if (conv_abort)
        result <= fill_partial(dac_code, nbits, last_bit);
      // start bit: hardware clear on end, sleep kill or disable
      if (wr_ctrl) begin
        chs     <= reg_wdata[`ADCS_CHS_MSB:`ADCS_CHS_LSB];
        conv_on <= reg_wdata[`ADCS_BIT_ON];
      end
      if (sw_go_set || special_event_trig)
        go <= 1'b1;
      else if (sw_go_clr || conv_done || sleep_kill || !conv_on)
        go <= 1'b0;
      if (reg_wr && reg_addr == `ADCS_ADDR_TIMING_FMT) begin
        justify_select <= reg_wdata[`ADCS_BIT_JUSTIFY];
        acq_sel        <= reg_wdata[`ADCS_ACQ_MSB:`ADCS_ACQ_LSB];
        clk_sel        <= reg_wdata[`ADCS_CLK_MSB:`ADCS_CLK_LSB];
      end
      if (conv_done)
        conv_done_flag <= 1'b1;
      else if (wr_flag)
        conv_done_flag <= reg_wdata[`ADCS_BIT_DONE];
      if (reg_wr && reg_addr == `ADCS_ADDR_PERIPH_EN)
        conv_irq_enable <= reg_wdata[`ADCS_BIT_IRQ_EN];
      // rc conversion in sleep without interrupt powers down after
      if (!sleep_mode)
        sleep_off <= 1'b0;
      else if (conv_done && frc_sel && !conv_irq_enable)
        sleep_off <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // outputs to the analog core and system
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      channel_select  <= 4'h0;
      sample_connect  <= 1'b0;
      converter_power <= 1'b0;
      conv_active     <= 1'b0;
      wake_req        <= 1'b0;
      timer_reset     <= 1'b0;
    end else begin
      // channel code passed straight to the input mux
      channel_select  <= chs;
      // power off in sleep on non-rc clock, enable bit untouched
      converter_power <= conv_on & ~(sleep_mode & ~frc_sel) & ~sleep_off;
      sample_connect  <= conv_on & ~(sleep_mode & ~frc_sel) & ~sleep_off
                       & (next_state == S_IDLE || next_state == S_DLY
                          || next_state == S_ACQ);
      conv_active     <= (next_state == S_CONV);
      // wake on flag with interrupt enabled in sleep
      wake_req        <= sleep_mode & conv_irq_enable
                       & (conv_done_flag | conv_done);
      timer_reset     <= special_event_trig;
    end
  end
  // ----------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  // justification applied on read
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADCS_ADDR_CHAN_CTRL:   reg_rdata <= {2'b00, chs, go, conv_on};
        `ADCS_ADDR_TIMING_FMT:  reg_rdata <= {justify_select, 1'b0, acq_sel, clk_sel};
        `ADCS_ADDR_RESULT_HIGH: reg_rdata <= justify_select ? {6'h00, result[9:8]}
                                                           : result[9:2];
        `ADCS_ADDR_RESULT_LOW:  reg_rdata <= justify_select ? result[7:0]
                                                           : {result[1:0], 6'h00};
        `ADCS_ADDR_PERIPH_FLAG: reg_rdata <= {1'b0, conv_done_flag, 6'h00};
        `ADCS_ADDR_PERIPH_EN:   reg_rdata <= {1'b0, conv_irq_enable, 6'h00};
        default:                reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

/* File: bench/adcs_seq_props.sv */
// port-level relations of the conversion sequencer
// assumes one clock domain, bound onto adcs_seq
`timescale 1ns/1ps
module adcs_seq_props (
  // clock and reset
  input wire       clk_sys,
  input wire       rst_n,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // power, trigger, core
  input wire       sleep_mode,
  input wire       special_event_trig,
  input wire       timer_reset,
  input wire       wake_req,
  input wire [3:0] channel_select,
  input wire       sample_connect,
  input wire       converter_power,
  input wire       conv_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_trig; timer_reset == $past(special_event_trig); endproperty
  a_trig: assert property (p_trig) else $error("timer reset off trigger");
  property p_wake; wake_req |-> $past(sleep_mode); endproperty
  a_wake: assert property (p_wake) else $error("wake outside sleep");
  property p_chan;
    (reg_wr && reg_addr == 3'h0) |-> ##2 channel_select == $past(reg_wdata[5:2], 2);
  endproperty
  a_chan: assert property (p_chan) else $error("channel not applied");
  property p_conv; $rose(conv_active) |-> conv_active [*8]; endproperty
  a_conv: assert property (p_conv) else $error("conversion too short");
  property p_gap; $fell(conv_active) |-> !sample_connect [*3]; endproperty
  a_gap: assert property (p_gap) else $error("channel reconnected early");
  property p_excl; !(sample_connect && conv_active); endproperty
  a_excl: assert property (p_excl) else $error("sampling during conversion");
  property p_pwr; conv_active |-> converter_power; endproperty
  a_pwr: assert property (p_pwr) else $error("converting unpowered");
  property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside slot");
endmodule
bind adcs_seq adcs_seq_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sleep_mode(sleep_mode), .special_event_trig(special_event_trig), .timer_reset(timer_reset),
  .wake_req(wake_req), .channel_select(channel_select), .sample_connect(sample_connect),
  .converter_power(converter_power), .conv_active(conv_active));

/* File: bench/adc_conversion_sequencer_tb.sv */
// self-checking bench for the conversion sequencer
// assumes adcs_seq on the compile list; comparator modelled here
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
  localparam IC = 2;
  reg        clk_sys, rst_n, reg_wr, reg_rd, sleep_mode, special_event_trig, frc_clk, cmp_in;
  reg  [2:0] reg_addr;
  reg  [7:0] reg_wdata, d, e;
  reg  [9:0] target;
  reg [31:0] seed;
  wire [7:0] reg_rdata;
  wire [3:0] channel_select;
  wire [9:0] dac_code;
  wire       timer_reset, wake_req, sample_connect, converter_power, conv_active;
  integer    err_count, n_checks, t0, t1, len, i;
  adcs_seq #(.INSTR_CLKS(IC)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_mode(sleep_mode), .special_event_trig(special_event_trig),
    .timer_reset(timer_reset), .wake_req(wake_req), .frc_clk(frc_clk), .cmp_in(cmp_in),
    .channel_select(channel_select), .sample_connect(sample_connect),
    .converter_power(converter_power), .conv_active(conv_active), .dac_code(dac_code));
  initial begin clk_sys = 0; forever #10 clk_sys = ~clk_sys; end
  initial begin frc_clk = 0; forever #55 frc_clk = ~frc_clk; end
  // comparator: high while the held input is not below the trial code
  always @(posedge clk_sys) cmp_in <= (target >= dac_code);
  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function [31:0] lfsr(input [31:0] s); lfsr = {s[30:0], s[31]^s[21]^s[1]^s[0]}; endfunction
  function [7:0] div_of(input [2:0] c); div_of = 8'h02 << (c[1:0] * 2 + c[2]); endfunction
  function [7:0] acq_tads(input [2:0] a); acq_tads = a < 5 ? 2 * a : 4 * a - 8; endfunction
  function [15:0] fmt(input [9:0] r, input j); fmt = j ? {6'h00, r} : {r, 6'h00}; endfunction
  // partial result: top bits match, the rest copy the last decided bit
  function abort_ok(input [9:0] r, input [9:0] t);
    integer n;
    reg [9:0] m;
    abort_ok = 0;
    for (n = 0; n <= 10; n++) begin
      m = ~(10'h3ff >> n);
      if (r === ((t & m) | ((n > 0 && r[10 - n]) ? ~m : 10'h000))) abort_ok = 1;
    end
  endfunction
  // ----------------------------------------
  // bus and sequence tasks
  // ----------------------------------------
  task tally_and_finish;
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] x);
    n_checks++;
    if (g !== x) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
      err_count++;
    end
  endtask
  task wr(input [2:0] a, input [7:0] v);
    @(posedge clk_sys); reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk_sys); reg_wr <= 0;
  endtask
  task rd(input [2:0] a);
    @(posedge clk_sys); reg_rd <= 1; reg_addr <= a;
    @(posedge clk_sys); reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task wait_rise;
    t1 = 0;
    while (!conv_active && t1 < 3000) begin @(posedge clk_sys); #1 t1++; end
  endtask
  task wait_fall;
    len = 0;
    while (conv_active && len < 3000) begin @(posedge clk_sys); #1 len++; end
  endtask
  task start(input [7:0] tf, input [3:0] c);
    wr(1, tf); wr(0, {2'h0, c, 2'h1}); wr(0, {2'h0, c, 2'h3}); wait_rise;
  endtask
  task finish(input [3:0] c);
    wait_fall;
    rd(4); chk(d, 8'h40);
    rd(4); chk(d, 8'h40);
    rd(0); chk(d, {2'h0, c, 2'h1});
    wr(4, 8'h00); rd(4); chk(d, 8'h00);
    repeat (140) @(posedge clk_sys);
    #1 chk(sample_connect, 1);
  endtask
  initial begin #1000000; err_count++; tally_and_finish; end
  initial begin
    {reg_wr, reg_rd, sleep_mode, special_event_trig} = 0;
    reg_addr = 0; reg_wdata = 0; target = 0; rst_n = 0;
    seed = 32'h00014915; err_count = 0; n_checks = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1;
    wr(2, 8'hff);
    for (i = 0; i < 8; i++) begin rd(i); chk(d, 8'h00); end
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      e = i < 2 ? 4'he + i : seed[3:0];
      wr(0, {e[3:0], 2'h0}); repeat (3) @(posedge clk_sys);
      chk(channel_select, e[3:0]);
    end
    // start while off is dropped
    wr(0, 8'h02); repeat (3) @(posedge clk_sys);
    #1 chk(conv_active, 0); rd(0); chk(d, 8'h00);
    for (i = 0; i < 8; i++) if (i[1:0] != 2'h3) begin
      start(i[7:0], 4'h1); finish(4'h1); chk(len, 11 * div_of(i));
    end
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed); target = seed[9:0];
      start({seed[10], 1'b0, i[2:0], 3'h1}, 4'h2);
      if (i == 0) t0 = t1;
      chk(t1 - t0, acq_tads(i) * 8 - (i ? IC : 0));
      finish(4'h2);
      rd(2); e = d; rd(3); chk({e, d}, fmt(target, seed[10]));
    end
    start(8'h03, 4'h2); chk(t1 - t0, IC); finish(4'h2);
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed); target = seed[9:0];
      start(8'h01, 4'h3); repeat (10 + seed[15:10]) @(posedge clk_sys);
      wr(0, 8'h0d); repeat (40) @(posedge clk_sys);
      rd(2); e = d; rd(3); chk(abort_ok({e, d[7:6]}, target), 1);
      wr(4, 8'h00);
    end
    // sleep with a divided clock aborts and powers down
    start(8'h06, 4'h0); repeat (10) @(posedge clk_sys); sleep_mode <= 1;
    repeat (4) @(posedge clk_sys);
    #1 chk({conv_active, converter_power}, 0); rd(0); chk(d, 8'h01);
    @(posedge clk_sys) sleep_mode <= 0; repeat (140) @(posedge clk_sys);
    wr(5, 8'h40); start(8'h03, 4'h0); @(posedge clk_sys) sleep_mode <= 1;
    wait_fall; repeat (2) @(posedge clk_sys); #1 chk(wake_req, 1);
    @(posedge clk_sys) sleep_mode <= 0; wr(4, 8'h00); wr(5, 8'h00);
    repeat (40) @(posedge clk_sys);
    start(8'h03, 4'h0); @(posedge clk_sys) sleep_mode <= 1; wait_fall;
    repeat (20) @(posedge clk_sys);
    #1 chk({wake_req, converter_power}, 0); rd(0); chk(d, 8'h01);
    @(posedge clk_sys) sleep_mode <= 0; wr(4, 8'h00); repeat (40) @(posedge clk_sys);
    wr(1, 8'h01); wr(0, 8'h01);
    @(posedge clk_sys) special_event_trig <= 1;
    @(posedge clk_sys) special_event_trig <= 0;
    wait_rise; chk(conv_active, 1); finish(4'h0);
    start(8'h06, 4'h5); repeat (20) @(posedge clk_sys); rst_n <= 0;
    repeat (2) @(posedge clk_sys); rst_n <= 1;
    #1 chk(conv_active, 0); rd(0); chk(d, 8'h00); rd(1); chk(d, 8'h00);
    tally_and_finish;
  end
endmodule
